//--- hdl/lmcp_pkg.sv
package lmcp_pkg;
    // Framing bytes
    localparam logic [7:0] LMCP_CR = 8'h0D;
    localparam logic [7:0] LMCP_ID_FAR = 8'h66;
    localparam logic [7:0] LMCP_ID_NEAR = 8'h62;
    localparam logic [7:0] LMCP_ID_ABS = 8'h73;
    localparam logic [7:0] LMCP_ANS_EOR = 8'h74;
    localparam logic [7:0] LMCP_ST_OK = 8'h00;
    localparam logic [7:0] LMCP_SS_START = 8'h01;
    localparam logic [7:0] LMCP_SS_STOP = 8'h00;
    // Motor identifiers
    localparam logic [7:0] LMCP_MOT_FOCUS = 8'h01;
    localparam logic [7:0] LMCP_MOT_ZOOM = 8'h02;
    localparam logic [7:0] LMCP_MOT_IRIS = 8'h03;
    localparam logic [7:0] LMCP_MOT_IRCUT = 8'h04;
    localparam logic LMCP_TYPE_DC = 1'b1;
    localparam logic LMCP_TYPE_STEP = 1'b0;
    // Bus and frame geometry
    localparam logic [6:0] LMCP_I2C_ADDR = 7'h10;
    localparam int LMCP_FIFO_DEPTH = 512;
    localparam int LMCP_FIFO_AW = 9;
    localparam logic [3:0] LMCP_MOVE_LEN = 4'h7;
    localparam logic [3:0] LMCP_FRM_MAX = 4'h8;
    localparam logic [23:0] LMCP_RESP_EOR = {LMCP_ANS_EOR, LMCP_ST_OK, LMCP_CR};
    localparam logic [23:0] LMCP_RESP_RST = 24'h000000;
    // Timing
    localparam int LMCP_CLK_PERIOD_NS = 40;
    localparam int LMCP_CLK_HZ = 1000000000 / LMCP_CLK_PERIOD_NS;
    localparam logic [25:0] LMCP_TICK_MOD = 26'(LMCP_CLK_HZ);
    // Speed limits after reset
    localparam logic [15:0] LMCP_MIN_SPD_RST = 16'h0001;
    localparam logic [15:0] LMCP_MAX_SPD_RST = 16'hFFFF;

    typedef enum logic [1:0] {
        LMCP_BUS_I2C_SRV = 2'h0,
        LMCP_BUS_USB = 2'h1,
        LMCP_BUS_UART = 2'h2
    } lmcp_mode_t;

    typedef enum logic [1:0] {
        LMCP_IDLE = 2'b00,
        LMCP_SEEK = 2'b01,
        LMCP_RUN = 2'b11,
        LMCP_DONE = 2'b10
    } lmcp_state_t;

    typedef struct packed {
        logic is_dc;
        logic use_far;
        logic use_near;
        logic [15:0] min_spd;
        logic [15:0] max_spd;
    } lmcp_cfg_t;

    typedef struct packed {
        logic [2:0] motor;
        logic dir_far;
        logic step;
        logic dc_on;
        logic busy;
    } lmcp_drive_t;

    function automatic logic [15:0] lmcp_word(input logic [7:0] hi, input logic [7:0] lo);
        lmcp_word = {hi, lo};
    endfunction : lmcp_word

    function automatic lmcp_cfg_t lmcp_cfg_rst(input int idx);
        lmcp_cfg_t c;
        c.is_dc = (idx == 3) ? LMCP_TYPE_DC : LMCP_TYPE_STEP;
        c.use_far = 1'b0;
        c.use_near = 1'b0;
        c.min_spd = LMCP_MIN_SPD_RST;
        c.max_spd = LMCP_MAX_SPD_RST;
        lmcp_cfg_rst = c;
    endfunction : lmcp_cfg_rst
endpackage : lmcp_pkg

//--- hdl/lmcp_fifo.sv
`timescale 1ns/1ps
module lmcp_fifo
    import lmcp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic rd_ready
);
    logic [7:0] mem [0:LMCP_FIFO_DEPTH-1];
    logic [LMCP_FIFO_AW:0] wp_q;
    logic [LMCP_FIFO_AW:0] rp_q;
    wire ptr_low_eq = (wp_q[LMCP_FIFO_AW-1:0] == rp_q[LMCP_FIFO_AW-1:0]);
    wire is_full = ptr_low_eq && (wp_q[LMCP_FIFO_AW] != rp_q[LMCP_FIFO_AW]);
    wire is_empty = (wp_q == rp_q);
    wire do_wr = wr_valid && !is_full;
    wire do_rd = rd_ready && !is_empty;

    assign wr_ready = !is_full;
    assign rd_valid = !is_empty;
    assign rd_data = mem[rp_q[LMCP_FIFO_AW-1:0]];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_q[LMCP_FIFO_AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule : lmcp_fifo

//--- hdl/lmcp_top.sv
`timescale 1ns/1ps
// Functional notes
// RULE_01: One bus mode active, USB by default
// RULE_02: USB busy: bytes wait in 512-byte queue
// RULE_03: Host waits for completion before next command
// RULE_04: Lone carriage return discards partial frame
// RULE_05: Discarded commands get no answer
// RULE_06: I2C server answers address 0x10
// RULE_07: Frames start with identifier, end 0x0D
// RULE_08: Response buffer survives reads
// RULE_09: Host may send 0x76 to overwrite answer; the code drops 0x76 as an unknown identifier and keeps the answer
// RULE_10: Decode far, near and absolute moves
// RULE_11: Absolute move: motors 1-2 with switches
// RULE_12: Step count is high byte first
// RULE_13: DC motors reinterpret count and speed
// RULE_14: Speed must lie within configured limits
// RULE_15: Start byte starts, stop zeroes remaining
// RULE_16: USB stop has no effect while moving
// RULE_17: Completion answer is three bytes
// RULE_18: Answer is 0x74, 0x00, terminator
// RULE_19: Motor four defaults to DC type
// RULE_20: DC drive lasts count pulses of 1/speed
// RULE_21: Decode after terminator, drop unknown identifiers
// RULE_22: Answer only after count done or stop
module lmcp_top
    import lmcp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    input wire logic mode_load,
    input wire logic [1:0] mode_in,
    output logic [2:0] mode_sel,
    input wire logic addr_valid,
    input wire logic [7:0] addr_byte,
    output logic addr_match,
    output logic addr_read,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_motor,
    input wire lmcp_cfg_t cfg_in,
    input wire logic [1:0] end_point_switch,
    output lmcp_drive_t drive,
    input wire logic [1:0] resp_idx,
    output logic [7:0] resp_byte,
    output logic resp_new
);
    default clocking cb @(posedge ref_clk); endclocking
    // Reset release synchroniser
    logic [1:0] rst_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    wire rst_n_s = rst_q[1];
    default disable iff (!rst_n_s);
    // Bus mode
    lmcp_mode_t mode_q;
    logic [2:0] mode_sel_q;
    wire mode_legal = (mode_in == LMCP_BUS_I2C_SRV) || (mode_in == LMCP_BUS_USB)
        || (mode_in == LMCP_BUS_UART);
    wire lmcp_mode_t mode_d = (mode_load && mode_legal) ? lmcp_mode_t'(mode_in) : mode_q;
    wire is_usb = (mode_q == LMCP_BUS_USB);
    wire is_i2c = (mode_q == LMCP_BUS_I2C_SRV);
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            mode_q <= LMCP_BUS_USB;
            mode_sel_q <= 3'h2;
        end else begin
            mode_q <= mode_d; // [RULE_01]
            mode_sel_q <= 3'h1 << mode_d;
        end
    end
    assign mode_sel = mode_sel_q;
    // Address recognition in server mode
    logic addr_match_q;
    logic addr_read_q;
    wire addr_hit = is_i2c && addr_valid && (addr_byte[7:1] == LMCP_I2C_ADDR); // [RULE_06]
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            addr_match_q <= 1'b0;
            addr_read_q <= 1'b0;
        end else begin
            addr_match_q <= addr_hit;
            addr_read_q <= addr_hit && addr_byte[0];
        end
    end
    assign addr_match = addr_match_q;
    assign addr_read = addr_read_q;
    // Motor setup
    lmcp_cfg_t cfg_q [0:3];
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int i = 0; i < 4; i++) begin
                cfg_q[i] <= lmcp_cfg_rst(i); // [RULE_19]
            end
        end else if (cfg_wr) begin
            cfg_q[cfg_motor] <= cfg_in;
        end
    end
    // End-point switch synchroniser
    logic [1:0] sw_m_q;
    logic [1:0] sw_s_q;
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            sw_m_q <= 2'b00;
            sw_s_q <= 2'b00;
        end else begin
            sw_m_q <= end_point_switch;
            sw_s_q <= sw_m_q;
        end
    end
    // Input queue
    lmcp_state_t st_q;
    lmcp_state_t st_d;
    logic q_valid;
    logic [7:0] q_data;
    wire moving = (st_q != LMCP_IDLE);
    wire pop_ready = !(is_usb && moving); // [RULE_02] [RULE_16]
    wire pop = q_valid && pop_ready;
    lmcp_fifo u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n_s),
        .wr_valid(rx_valid),
        .wr_data(rx_data),
        .wr_ready(rx_ready),
        .rd_valid(q_valid),
        .rd_data(q_data),
        .rd_ready(pop_ready)
    );
    // Frame assembly
    logic [7:0] frm_q [0:6];
    logic [3:0] idx_q;
    wire is_cr = (q_data == LMCP_CR);
    wire frame_end = pop && is_cr; // [RULE_04] [RULE_07] [RULE_21]
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            idx_q <= 4'h0;
        end else if (pop) begin
            if (is_cr) begin
                idx_q <= 4'h0; // [RULE_04]
            end else if (idx_q < LMCP_FRM_MAX) begin
                idx_q <= idx_q + 4'h1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (pop && !is_cr && (idx_q < LMCP_MOVE_LEN)) begin
            frm_q[idx_q[2:0]] <= q_data;
        end
    end
    // Move decoding
    wire [7:0] cmd_id = frm_q[0];
    wire [7:0] mot_id = frm_q[1];
    wire [7:0] ss_byte = frm_q[4];
    wire id_abs = (cmd_id == LMCP_ID_ABS);
    wire is_move = (idx_q == LMCP_MOVE_LEN) && ((cmd_id == LMCP_ID_FAR)
        || (cmd_id == LMCP_ID_NEAR) || id_abs); // [RULE_10] [RULE_21]
    wire mot_ok = (mot_id >= LMCP_MOT_FOCUS) && (mot_id <= LMCP_MOT_IRCUT);
    wire [1:0] mot_idx = 2'(mot_id[1:0] - 2'h1);
    wire lmcp_cfg_t m_cfg = cfg_q[mot_idx];
    wire [15:0] cnt_w = lmcp_word(frm_q[2], frm_q[3]); // [RULE_12]
    wire [15:0] spd_w = lmcp_word(frm_q[5], frm_q[6]);
    wire spd_ok = (spd_w != 16'h0000) && (spd_w >= m_cfg.min_spd)
        && (spd_w <= m_cfg.max_spd); // [RULE_14]
    wire sw_motor = (mot_id == LMCP_MOT_FOCUS) || (mot_id == LMCP_MOT_ZOOM);
    wire abs_ok = !id_abs || (sw_motor && (m_cfg.use_far || m_cfg.use_near)); // [RULE_11]
    wire start_ok = is_move && mot_ok && (ss_byte == LMCP_SS_START) && spd_ok && abs_ok;
    wire launch = frame_end && start_ok && (st_q == LMCP_IDLE); // [RULE_15]
    logic [2:0] motor_q;
    wire stop_take = frame_end && is_move && (ss_byte == LMCP_SS_STOP)
        && ((st_q == LMCP_SEEK) || (st_q == LMCP_RUN))
        && (mot_id[2:0] == motor_q) && (mot_id[7:3] == 5'h00); // [RULE_05] [RULE_15]
    // Rate generator: one tick every 1/speed seconds
    logic [25:0] acc_q;
    logic [15:0] spd_q;
    logic [15:0] rem_q;
    logic is_dc_q;
    logic dir_q;
    wire [25:0] acc_sum = acc_q + {10'h000, spd_q};
    wire tick = (acc_sum >= LMCP_TICK_MOD); // [RULE_13] [RULE_20]
    wire sw_hit = motor_q[1] ? sw_s_q[1] : sw_s_q[0];
    wire rem_zero = (rem_q == 16'h0000);
    wire step_d = tick && !is_dc_q && (((st_q == LMCP_SEEK) && !sw_hit)
        || ((st_q == LMCP_RUN) && !rem_zero));
    wire dc_on_d = (st_q == LMCP_RUN) && is_dc_q && !rem_zero; // [RULE_13] [RULE_20]
    always_comb begin
        st_d = st_q;
        case (st_q)
            LMCP_IDLE: begin
                if (launch) begin
                    st_d = id_abs ? LMCP_SEEK : LMCP_RUN;
                end
            end
            LMCP_SEEK: begin
                if (stop_take || sw_hit) begin
                    st_d = LMCP_RUN;
                end
            end
            LMCP_RUN: begin
                if (tick && rem_zero) begin
                    st_d = LMCP_DONE; // [RULE_22]
                end
            end
            default: begin
                st_d = LMCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_q <= LMCP_IDLE;
            acc_q <= 26'h0000000;
        end else begin
            st_q <= st_d;
            if (st_q == LMCP_IDLE) begin
                acc_q <= 26'h0000000;
            end else begin
                acc_q <= tick ? 26'(acc_sum - LMCP_TICK_MOD) : acc_sum;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rem_q <= 16'h0000;
        end else if (launch) begin
            rem_q <= cnt_w;
        end else if (stop_take) begin
            rem_q <= 16'h0000; // [RULE_15]
        end else if ((st_q == LMCP_RUN) && tick && !rem_zero) begin
            rem_q <= rem_q - 16'h0001;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            motor_q <= 3'h0;
            spd_q <= 16'h0000;
            is_dc_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (launch) begin
            motor_q <= mot_id[2:0];
            spd_q <= spd_w;
            is_dc_q <= m_cfg.is_dc;
            dir_q <= id_abs ? m_cfg.use_far : (cmd_id == LMCP_ID_FAR); // [RULE_10]
        end else if ((st_q == LMCP_SEEK) && sw_hit) begin
            dir_q <= !dir_q;
        end
    end
    lmcp_drive_t drive_q;
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            drive_q <= '0;
        end else begin
            drive_q <= '{motor: motor_q, dir_far: dir_q, step: step_d, dc_on: dc_on_d,
                busy: moving};
        end
    end
    assign drive = drive_q;
    // Response buffer, kept until the next answer
    logic [23:0] resp_q;
    logic resp_new_q;
    logic [7:0] resp_byte_q;
    wire resp_wr = (st_q == LMCP_DONE);
    wire [7:0] resp_sel = (resp_idx == 2'h0) ? resp_q[23:16] :
        (resp_idx == 2'h1) ? resp_q[15:8] :
        (resp_idx == 2'h2) ? resp_q[7:0] : 8'h00;
    always_ff @(posedge ref_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            resp_q <= LMCP_RESP_RST;
            resp_new_q <= 1'b0;
            resp_byte_q <= 8'h00;
        end else begin
            if (resp_wr) begin
                resp_q <= LMCP_RESP_EOR; // [RULE_17] [RULE_18]
            end
            resp_new_q <= resp_wr;
            resp_byte_q <= resp_sel; // [RULE_08]
        end
    end
    assign resp_byte = resp_byte_q;
    assign resp_new = resp_new_q;
    property p_one_mode;
        $onehot(mode_sel_q);
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("bus mode not one-hot"); // [RULE_01]
    // The frame index must not move while a USB move runs
    property p_usb_hold;
        is_usb && moving |=> $stable(idx_q);
    endproperty
    a_usb_hold: assert property (p_usb_hold) else $error("queue drained in busy USB"); // [RULE_02]
    property p_cr_clears;
        frame_end |=> (idx_q == 4'h0);
    endproperty
    a_cr_clears: assert property (p_cr_clears) else $error("terminator kept frame"); // [RULE_04]
    property p_discard_silent;
        (st_q == LMCP_IDLE) && frame_end && !start_ok |=> (st_q == LMCP_IDLE) ##1 !resp_wr;
    endproperty
    a_discard_silent: assert property (p_discard_silent) else $error("discard answered"); // [RULE_05]
    property p_addr;
        addr_hit |=> addr_match && (addr_read == $past(addr_byte[0]));
    endproperty
    a_addr: assert property (p_addr) else $error("address not matched"); // [RULE_06]
    property p_resp_hold;
        !resp_wr |=> $stable(resp_q);
    endproperty
    a_resp_hold: assert property (p_resp_hold) else $error("response changed"); // [RULE_08]
    property p_abs_motor;
        launch && id_abs |-> sw_motor && (m_cfg.use_far || m_cfg.use_near);
    endproperty
    a_abs_motor: assert property (p_abs_motor) else $error("bad absolute move"); // [RULE_11]
    property p_speed;
        launch |-> (spd_w >= m_cfg.min_spd) && (spd_w <= m_cfg.max_spd);
    endproperty
    a_speed: assert property (p_speed) else $error("speed out of range"); // [RULE_14]
    // A stop landing on the final tick may already see the move finish
    property p_stop;
        stop_take |=> rem_zero && (st_q != LMCP_IDLE) && (st_q != LMCP_SEEK);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not applied"); // [RULE_15]
    property p_answer;
        (st_q == LMCP_RUN) && tick && rem_zero |=> ##1 resp_new && (resp_q == LMCP_RESP_EOR);
    endproperty
    a_answer: assert property (p_answer) else $error("wrong completion answer"); // [RULE_18]
    property p_done_cause;
        resp_wr |-> $past(rem_zero) && $past(st_q == LMCP_RUN);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("early answer"); // [RULE_22]
    c_launch: cover property (launch);
    c_abs: cover property (launch && id_abs ##[1:1000] sw_hit);
    c_stop: cover property (stop_take);
    c_answer: cover property (resp_new);
endmodule : lmcp_top

//--- test/lmcp_host.sv
`timescale 1ns/1ps
module lmcp_host (
    input wire logic ref_clk,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hA5;
    end

    // Valid stays high across the bytes of one call
    task automatic send(input logic [7:0] f[$]);
        logic ok;
        foreach (f[i]) begin
            rx_valid = 1'b1;
            rx_data = f[i];
            ok = 1'b0;
            while (ok !== 1'b1) begin
                @(negedge ref_clk);
                ok = rx_ready;
                @(posedge ref_clk);
            end
            #1;
        end
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask : send
endmodule : lmcp_host

//--- test/test_lmcp_top.sv
`timescale 1ns/1ps
module test_lmcp_top;
    import lmcp_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n, rx_valid, rx_ready, mode_load, addr_valid, addr_match, addr_read;
    logic cfg_wr, resp_new, last_dir;
    logic [7:0] rx_data, addr_byte, resp_byte;
    logic [1:0] mode_in, cfg_motor, end_point_switch, resp_idx;
    logic [2:0] mode_sel;
    lmcp_cfg_t cfg_in;
    lmcp_drive_t drive;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 32'h6349;
    int n_step, n_dc, n_resp, k, exp_mode;
    int c_min[4], c_max[4];
    bit c_dc[4], c_stop[4];
    logic [7:0] q[$];

    always #20 ref_clk = ~ref_clk;

    lmcp_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .mode_load(mode_load), .mode_in(mode_in),
        .mode_sel(mode_sel), .addr_valid(addr_valid), .addr_byte(addr_byte),
        .addr_match(addr_match), .addr_read(addr_read), .cfg_wr(cfg_wr),
        .cfg_motor(cfg_motor), .cfg_in(cfg_in), .end_point_switch(end_point_switch),
        .drive(drive), .resp_idx(resp_idx), .resp_byte(resp_byte), .resp_new(resp_new));

    lmcp_host u_host (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data));

    always @(posedge ref_clk) begin
        if (drive.step === 1'b1) n_step++;
        if (drive.dc_on === 1'b1) n_dc++;
        if (drive.step === 1'b1 || drive.dc_on === 1'b1) last_dir = drive.dir_far;
        if (resp_new === 1'b1) n_resp++;
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic await();
        for (int i = 0; i < 6000 && n_resp == 0; i++) tick(1);
    endtask : await

    task automatic show(input logic [23:0] e);
        for (int i = 0; i < 3; i++) begin
            resp_idx = 2'(i);
            tick(2);
            check(resp_byte, e[23 - 8 * i -: 8]);
        end
    endtask : show

    task automatic cfg(input int m, input bit dc, input bit far, input int mn, input int mx);
        cfg_motor = 2'(m);
        cfg_in = '0;
        cfg_in.is_dc = dc;
        cfg_in.use_far = far;
        cfg_in.use_near = !far;
        cfg_in.min_spd = 16'(mn);
        cfg_in.max_spd = 16'(mx);
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        c_dc[m] = dc;
        c_stop[m] = 1'b1;
        c_min[m] = mn;
        c_max[m] = mx;
    endtask : cfg

    // Expected step count of a frame without its terminator, or -1 when dropped
    function automatic int model(input logic [7:0] f[$]);
        int m;
        int spd;
        if (f.size() != 7) return -1;
        m = int'(f[1]) - 1;
        spd = 256 * f[5] + f[6];
        if (m < 0 || m > 3 || f[4] != 8'h01) return -1;
        if (f[0] != 8'h66 && f[0] != 8'h62 && !(f[0] == 8'h73 && m < 2 && c_stop[m]))
            return -1;
        if (spd == 0 || spd < c_min[m] || spd > c_max[m]) return -1;
        return 256 * f[2] + f[3];
    endfunction : model

    task automatic move(input logic [7:0] f[$]);
        int e;
        e = model(f);
        n_step = 0;
        n_dc = 0;
        n_resp = 0;
        f.push_back(LMCP_CR);
        u_host.send(f);
        if (e < 0) begin
            tick(1200);
            check(n_resp, 0);
        end else begin
            await();
            check(n_resp, 1);
            show(24'h74000D);
            if (c_dc[f[1] - 1]) begin
                check(n_step, 0);
                check((n_dc + 191) / 381, e);
            end else if (f[0] != 8'h73) begin
                check(n_step, e);
                check(last_dir, f[0] == 8'h66);
            end
        end
    endtask : move

    initial begin
        #3200000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        reset_n = 1'b0;
        mode_load = 1'b0;
        mode_in = 2'h0;
        addr_valid = 1'b0;
        addr_byte = 8'h00;
        cfg_wr = 1'b0;
        cfg_motor = 2'h0;
        cfg_in = '0;
        end_point_switch = 2'h0;
        resp_idx = 2'h0;
        for (k = 0; k < 4; k++) begin
            c_dc[k] = (k == 3);
            c_stop[k] = 1'b0;
            c_min[k] = 1;
            c_max[k] = 16'hFFFF;
        end
        exp_mode = 1;
        tick(8);
        reset_n = 1'b1;
        tick(3);
        check(mode_sel, 3'b010);
        show(24'h000000);
        move('{8'h66, 8'h01, 8'h00, 8'(1 + $unsigned($random(seed)) % 3), 8'h01, 8'hFF, 8'hFF});
        show(24'h74000D);
        move('{8'h62, 8'h02, 8'h00, 8'h02, 8'h01, 8'hFF, 8'hFF});
        for (k = 0; k < 6; k++) begin
            q = '{8'h66, 8'h01, 8'h00, 8'h01, 8'h01, 8'hFF, 8'hFF};
            case (k)
                0: q[0] = 8'h76;
                1: q[1] = 8'h05;
                2: q[1] = 8'h00;
                3: q[0] = 8'h73;
                4: q[4] = 8'h00;
                default: q.push_back(8'h01);
            endcase
            move(q);
        end
        u_host.send('{8'h66, 8'h01, 8'h00});
        tick(1);
        u_host.send('{LMCP_CR});
        tick(2);
        move('{8'h66, 8'h01, 8'h00, 8'h01, 8'h01, 8'hFF, 8'hFF});
        cfg(0, 1'b0, 1'b0, 16'h1000, 16'hF000);
        move('{8'h66, 8'h01, 8'h00, 8'h01, 8'h01, 8'h0F, 8'hFF});
        move('{8'h66, 8'h01, 8'h00, 8'h01, 8'h01, 8'hF0, 8'h01});
        move('{8'h62, 8'h01, 8'h00, 8'h01, 8'h01, 8'hF0, 8'h00});
        move('{8'h66, 8'h04, 8'h00, 8'h02, 8'h01, 8'hFF, 8'hFF});
        cfg(1, 1'b0, 1'b1, 1, 16'hFFFF);
        end_point_switch = 2'b10;
        move('{8'h73, 8'h02, 8'h00, 8'h01, 8'h01, 8'hFF, 8'hFF});
        // Seek toward the near stop until its switch closes, then count back
        end_point_switch = 2'b00;
        n_step = 0;
        n_resp = 0;
        u_host.send('{8'h73, 8'h01, 8'h00, 8'h01, 8'h01, 8'hF0, 8'h00, LMCP_CR});
        for (k = 0; k < 3000 && n_step < 2; k++) tick(1);
        check(drive.dir_far, 1'b0);
        end_point_switch = 2'b01;
        await();
        check(n_step, 3);
        check(last_dir, 1'b1);
        n_resp = 0;
        u_host.send('{8'h76, LMCP_CR});
        tick(20);
        check(n_resp, 0);
        show(24'h74000D);
        // Stop queued behind a move in USB mode arrives too late to act
        n_step = 0;
        n_resp = 0;
        u_host.send('{8'h66, 8'h03, 8'h00, 8'h02, 8'h01, 8'hFF, 8'hFF, LMCP_CR,
            8'h66, 8'h03, 8'h00, 8'h02, 8'h00, 8'hFF, 8'hFF, LMCP_CR});
        await();
        tick(1500);
        check(n_step, 2);
        check(n_resp, 1);
        // Bytes pile up while the motor runs
        n_resp = 0;
        u_host.send('{8'h62, 8'h03, 8'h00, 8'h03, 8'h01, 8'hFF, 8'hFF, LMCP_CR});
        tick(4);
        q = {};
        repeat (512) q.push_back(LMCP_CR);
        u_host.send(q);
        @(negedge ref_clk);
        check(rx_ready, 1'b0);
        tick(1);
        await();
        tick(1200);
        check(n_resp, 1);
        check(rx_ready, 1'b1);
        for (k = 1; k < 5; k++) begin
            mode_in = 2'(k % 4);
            mode_load = 1'b1;
            tick(1);
            mode_load = 1'b0;
            tick(1);
            if (k % 4 != 3) exp_mode = k % 4;
            check(mode_sel, 3'b001 << exp_mode);
            for (int j = 0; j < 3; j++) begin
                addr_byte = (j == 2) ? 8'($random(seed)) : 8'h20 + 8'(j);
                addr_valid = 1'b1;
                tick(1);
                addr_valid = 1'b0;
                check(addr_match, exp_mode == 0 && addr_byte[7:1] == 7'h10);
                check(addr_read, exp_mode == 0 && addr_byte[7:1] == 7'h10 && addr_byte[0]);
            end
        end
        n_step = 0;
        n_resp = 0;
        u_host.send('{8'h66, 8'h03, 8'h00, 8'h03, 8'h01, 8'hFF, 8'hFF, LMCP_CR});
        for (k = 0; k < 3000 && n_step == 0; k++) tick(1);
        check({drive.busy, drive.motor}, 4'hB);
        u_host.send('{8'h66, 8'h03, 8'h00, 8'h03, 8'h00, 8'hFF, 8'hFF, LMCP_CR});
        await();
        check(n_resp, 1);
        check(n_step < 3, 1'b1);
        show(24'h74000D);
        give_verdict();
    end
endmodule : test_lmcp_top
